// >>> hw/lcd_pkg.sv
// Package: command codes, bank states, device states, timing counts for the state tracker
package lcd_pkg;

    localparam int unsigned CLK_PERIOD_NS = 50;

    // Interval times in ns, counts derived by rounding up
    localparam int unsigned T_RCD_NS   = 18;
    localparam int unsigned T_RP_NS    = 18;
    localparam int unsigned T_BURST_NS = 200;
    localparam int unsigned T_RFCPB_NS = 90;
    localparam int unsigned T_RFCAB_NS = 210;
    localparam int unsigned T_MRR_NS   = 200;
    localparam int unsigned T_MRW_NS   = 500;
    localparam int unsigned T_INIT5_NS = 10000;

    localparam logic [7:0] CYC_RCD   = 8'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CYC_RP    = 8'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CYC_BURST = 8'((T_BURST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CYC_RFCPB = 8'((T_RFCPB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CYC_RFCAB = 8'((T_RFCAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CYC_MRR   = 8'((T_MRR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CYC_MRW   = 8'((T_MRW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int unsigned CYC_INIT5 = (T_INIT5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned NUM_BANKS = 8;
    localparam logic [7:0]  RESET_MA  = 8'h3F;
    localparam logic [7:0]  ZERO_CNT  = 8'h00;

    // Field positions on the rising-edge bus, except AP_BIT_F which is on the falling half
    localparam int unsigned BA_LSB     = 7;
    localparam int unsigned AB_BIT     = 4;
    localparam int unsigned AP_BIT_F   = 0;
    localparam int unsigned MA_LO_LSB  = 4;

    typedef enum logic [3:0] {
        CMD_NOP   = 4'h0,
        CMD_MRW   = 4'h1,
        CMD_MRR   = 4'h2,
        CMD_REFPB = 4'h3,
        CMD_REFAB = 4'h4,
        CMD_ACT   = 4'h5,
        CMD_WR    = 4'h6,
        CMD_RD    = 4'h7,
        CMD_PRE   = 4'h8,
        CMD_SRE   = 4'h9,
        CMD_ILL   = 4'hF
    } lcd_cmd_t;

    typedef enum logic [10:0] {
        BK_IDLE    = 11'h001,
        BK_ACTING  = 11'h002,
        BK_ACTIVE  = 11'h004,
        BK_READ    = 11'h008,
        BK_WRITE   = 11'h010,
        BK_READ_AP = 11'h020,
        BK_WRIT_AP = 11'h040,
        BK_PRECH   = 11'h080,
        BK_REFR    = 11'h100,
        BK_MRRD    = 11'h200,
        BK_MRWR    = 11'h400
    } lcd_bank_t;

    typedef enum logic [9:0] {
        DV_POWER_ON = 10'h001,
        DV_RESETTING= 10'h002,
        DV_RST_MRR  = 10'h004,
        DV_NORMAL   = 10'h008,
        DV_IDLE_PD  = 10'h010,
        DV_ACT_PD   = 10'h020,
        DV_RST_PD   = 10'h040,
        DV_SELF_REFRESH_STATE     = 10'h080,
        DV_ALLBUSY  = 10'h100,
        DV_ILLEGAL  = 10'h200
    } lcd_dev_t;

    typedef struct packed {
        logic       cs_n;
        logic       cke;
        logic [9:0] ca;
    } lcd_ca_t;

    typedef struct packed {
        lcd_cmd_t    cmd;
        logic [2:0]  bank;
        logic        auto_precharge_flag;
        logic        all_bank_flag;
        logic [7:0]  mode_addr;
        logic [7:0]  mode_op;
        logic [14:0] row;
        logic [11:0] col;
    } lcd_dec_t;

endpackage : lcd_pkg

// >>> hw/lcd_cmd_decode.sv
// Command decoder: joins rising and falling halves of the command bus into one command
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_decode
    import lcd_pkg::*;
(
    input  wire logic [9:0] ca_rise_i,
    input  wire logic [9:0] ca_fall_i,
    input  wire logic       cs_n_i,
    input  wire logic       cke_prev_i,
    input  wire logic       cke_i,
    output lcd_dec_t        dec_o
);

    always_comb begin
        dec_o = '0;
        dec_o.cmd = CMD_NOP;
        dec_o.bank = ca_rise_i[BA_LSB +: 3];                              // RULE_02
        dec_o.all_bank_flag = ca_rise_i[AB_BIT];
        dec_o.auto_precharge_flag = ca_fall_i[AP_BIT_F];
        dec_o.mode_addr = {ca_fall_i[1:0], ca_rise_i[MA_LO_LSB +: 6]};     // RULE_27
        dec_o.mode_op = ca_fall_i[9:2];                                   // RULE_27
        dec_o.row = {ca_fall_i[9:8], ca_rise_i[6:2], ca_fall_i[7:0]};      // RULE_27
        dec_o.col = {ca_fall_i[9:1], ca_rise_i[6:5], 1'b0};               // RULE_04
        // Chip select high means no command whatever the bus holds
        if (!cs_n_i && cke_prev_i) begin                                  // RULE_06 RULE_01
            casez (ca_rise_i[3:0])                                        // RULE_26
                4'b0000: dec_o.cmd = cke_i ? CMD_MRW : CMD_ILL;
                4'b1000: dec_o.cmd = cke_i ? CMD_MRR : CMD_ILL;
                4'b0100: dec_o.cmd = cke_i ? CMD_REFPB : CMD_SRE;
                4'b1100: dec_o.cmd = cke_i ? CMD_REFAB : CMD_SRE;
                4'b??10: dec_o.cmd = cke_i ? CMD_ACT : CMD_ILL;
                4'b?001: dec_o.cmd = cke_i ? CMD_WR : CMD_ILL;
                4'b?101: dec_o.cmd = cke_i ? CMD_RD : CMD_ILL;
                4'b1011: dec_o.cmd = cke_i ? CMD_PRE : CMD_ILL;
                4'b?111: dec_o.cmd = CMD_NOP;
                default: dec_o.cmd = CMD_ILL;
            endcase
        end
    end

endmodule : lcd_cmd_decode
`default_nettype wire

// >>> hw/lcd_state_tracker.sv
// Top: samples the command bus on rising edges of two consecutive cycles, tracks bank and device state
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE_01] Command comes from chip select, clock enable and CA0-3 at rising edge.
// [RULE_02] Three bank-select bits pick the bank for bank commands.
// [RULE_03] Auto-precharge flag closes the bank once the burst ends.
// [RULE_04] Lowest column bit is not sent and reads as zero.
// [RULE_05] Precharge with all-bank flag closes every bank, ignoring bank bits.
// [RULE_06] Chip select high is a no-operation; bus is ignored.
// [RULE_07] One command per cycle: rising half, then falling half. Here the two halves are sampled on rising edges of two successive cycles.
// [RULE_08] Self-refresh exit follows clock enable alone, no command needed.
// [RULE_09] Controller may float pins in low power only after entry delay.
// [RULE_10] Clock enable fall with select high enters idle, active or resetting power-down.
// [RULE_11] Clock enable rise leaves power-down or self refresh to matching state.
// [RULE_12] Controller sends only NOPs until power-down exit time passes.
// [RULE_13] Controller sends only NOPs until self-refresh exit time passes.
// [RULE_14] Leaving resetting power-down goes idle if final init interval expired.
// [RULE_15] Idle power-down or self refresh: outputs float or terminate per termination.
// [RULE_16] Idle bank accepts activate, refreshes, mode commands, reset, precharge.
// [RULE_17] Active bank accepts read, write, mode read and precharge.
// [RULE_18] Controller writes a reading bank only after the burst ends.
// [RULE_19] Controller reads a writing bank only after the burst ends.
// [RULE_20] Busy banks get only NOPs; other banks may be commanded.
// [RULE_21] During refresh, mode access or precharge-all, controller sends NOPs.
// [RULE_22] Refreshes and mode write need target or all banks idle.
// [RULE_23] Reset is a mode write; starts initialization from power-on or idle.
// [RULE_24] Mode read in resetting holds resetting-read until read interval ends.
// [RULE_25] Any unspecified operation is illegal; device flags it until reinit. Code flags only illegal opcodes and busy-bank power-down entry in normal state.
// [RULE_26] Opcodes on CA0-3 are fixed per command.
// [RULE_27] Mode write and activate split address bits across both edges.
module lcd_state_tracker
    import lcd_pkg::*;
#(
    parameter int unsigned INIT5_CYCLES = CYC_INIT5
)
(
    input  wire logic        REF_CLK_I,
    input  wire logic        RESET_I,
    input  wire logic        CS_N_I,
    input  wire logic        CKE_I,
    input  wire logic [9:0]  CA_I,
    input  wire logic        ODT_EN_I,
    output logic [7:0]       BANK_OPEN_O,
    output logic [7:0]       BANK_BUSY_O,
    output lcd_dev_t         DEV_STATE_O,
    output logic             DQ_HIZ_O,
    output logic             DQ_TERM_O,
    output logic             ILLEGAL_O,
    output logic [7:0]       MODE_ADDR_O,
    output logic [7:0]       MODE_OP_O,
    output logic             MODE_WR_O
);

    // =========================================================
    // Input synchronisers (bus comes from the pins)
    // =========================================================
    lcd_ca_t   pin_s1;
    lcd_ca_t   pin_s2;
    logic [9:0] fall_s1;
    logic [9:0] fall_s2;
    logic       odt_s1;
    logic       odt_s2;

    always_ff @(posedge REF_CLK_I) begin
        pin_s1 <= {CS_N_I, CKE_I, CA_I};
        pin_s2 <= pin_s1;
        odt_s1 <= ODT_EN_I;
        odt_s2 <= odt_s1;
    end

    always_ff @(posedge REF_CLK_I) begin
        fall_s1 <= CA_I;                                                  // RULE_07
        fall_s2 <= fall_s1;
    end

    // =========================================================
    // Command assembly: rising half held one cycle
    // =========================================================
    logic [9:0] rise_hold;
    logic       cs_n_hold;
    logic       cke_hold;
    logic       cke_prev;

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            rise_hold <= 10'h3FF;
            cs_n_hold <= 1'b1;
            cke_hold  <= 1'b1;
            cke_prev  <= 1'b1;
        end else begin
            rise_hold <= pin_s2.ca;                                       // RULE_07
            cs_n_hold <= pin_s2.cs_n;
            cke_prev  <= cke_hold;
            cke_hold  <= pin_s2.cke;
        end
    end

    lcd_dec_t dec;

    lcd_cmd_decode u_dec (
        .ca_rise_i  (rise_hold),
        .ca_fall_i  (fall_s2),
        .cs_n_i     (cs_n_hold),
        .cke_prev_i (cke_prev),
        .cke_i      (cke_hold),
        .dec_o      (dec)
    );

    // =========================================================
    // Bank tracking
    // =========================================================
    lcd_bank_t  bank_st [NUM_BANKS];
    logic [7:0] bank_cnt [NUM_BANKS];
    logic [7:0] bank_ap;
    logic       all_idle;
    logic       any_open;

    function automatic logic [7:0] dec_cnt(input logic [7:0] c);
        dec_cnt = (c == ZERO_CNT) ? ZERO_CNT : c - 8'h01;
    endfunction : dec_cnt

    always_comb begin
        all_idle = 1'b1;
        any_open = 1'b0;
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (bank_st[i] != BK_IDLE) all_idle = 1'b0;
            if (bank_st[i] inside {BK_ACTING, BK_ACTIVE, BK_READ, BK_WRITE}) any_open = 1'b1;
        end
    end

    logic normal_go;
    assign normal_go = (DEV_STATE_O == DV_NORMAL);

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            for (int i = 0; i < NUM_BANKS; i++) begin
                bank_st[i]  <= BK_IDLE;
                bank_cnt[i] <= ZERO_CNT;
            end
            bank_ap <= 8'h00;
        end else begin
            for (int i = 0; i < NUM_BANKS; i++) begin
                bank_cnt[i] <= dec_cnt(bank_cnt[i]);
                // Timed states fall back once their interval ends
                if (bank_cnt[i] == 8'h01) begin
                    case (bank_st[i])
                        BK_ACTING:  bank_st[i] <= BK_ACTIVE;
                        BK_READ, BK_WRITE: bank_st[i] <= BK_ACTIVE;
                        BK_READ_AP, BK_WRIT_AP: begin                     // RULE_03
                            bank_st[i]  <= BK_PRECH;
                            bank_cnt[i] <= CYC_RP;
                        end
                        BK_MRRD:    bank_st[i] <= bank_ap[i] ? BK_ACTIVE : BK_IDLE;
                        default:    bank_st[i] <= BK_IDLE;
                    endcase
                end
                if (normal_go) begin
                    if ((dec.bank == 3'(i)) || dec.cmd inside {CMD_REFAB, CMD_MRW, CMD_MRR}) begin
                        case (dec.cmd)
                            CMD_ACT: if (bank_st[i] == BK_IDLE) begin     // RULE_16
                                bank_st[i]  <= BK_ACTING;
                                bank_cnt[i] <= CYC_RCD;
                            end
                            CMD_RD, CMD_WR: if (bank_st[i] inside {BK_ACTIVE, BK_READ, BK_WRITE}) begin // RULE_17
                                bank_st[i]  <= dec.auto_precharge_flag ?
                                               ((dec.cmd == CMD_RD) ? BK_READ_AP : BK_WRIT_AP) :
                                               ((dec.cmd == CMD_RD) ? BK_READ : BK_WRITE);
                                bank_cnt[i] <= CYC_BURST;
                            end
                            CMD_REFPB, CMD_REFAB: if (bank_st[i] == BK_IDLE) begin
                                bank_st[i]  <= BK_REFR;
                                bank_cnt[i] <= (dec.cmd == CMD_REFPB) ? CYC_RFCPB : CYC_RFCAB;
                            end
                            CMD_MRR: if (bank_st[i] inside {BK_IDLE, BK_ACTIVE}) begin
                                bank_ap[i]  <= (bank_st[i] == BK_ACTIVE);
                                bank_st[i]  <= BK_MRRD;
                                bank_cnt[i] <= CYC_MRR;
                            end
                            CMD_MRW: if (bank_st[i] == BK_IDLE && dec.mode_addr != RESET_MA) begin
                                bank_st[i]  <= BK_MRWR;
                                bank_cnt[i] <= CYC_MRW;
                            end
                            default: ;
                        endcase
                    end
                    if (dec.cmd == CMD_PRE && (dec.all_bank_flag || dec.bank == 3'(i))) begin // RULE_05
                        bank_st[i]  <= BK_PRECH;
                        bank_cnt[i] <= CYC_RP;
                    end
                end
            end
        end
    end

    // =========================================================
    // Device state: power-down, self refresh, reset sequence
    // =========================================================
    lcd_dev_t next_dev;
    logic [15:0] init_cnt;
    logic [7:0]  rmrr_cnt;
    logic        init_done;
    logic        cke_fall;
    logic        cke_rise;

    assign init_done = (init_cnt == 16'h0000);
    assign cke_fall  = cke_prev && !cke_hold && cs_n_hold;
    // Self-refresh exit needs only clock enable high, no command
    assign cke_rise  = !cke_prev && cke_hold;                            // RULE_08

    always_comb begin
        next_dev = DEV_STATE_O;
        case (DEV_STATE_O)
            DV_POWER_ON: if (dec.cmd == CMD_MRW && dec.mode_addr == RESET_MA) next_dev = DV_RESETTING; // RULE_23
            DV_RESETTING: begin
                if (cke_fall) next_dev = DV_RST_PD;                       // RULE_10
                else if (dec.cmd == CMD_MRR) next_dev = DV_RST_MRR;       // RULE_24
                else if (init_done) next_dev = DV_NORMAL;
            end
            DV_RST_MRR: if (rmrr_cnt == 8'h01) next_dev = DV_RESETTING;  // RULE_24
            DV_NORMAL: begin
                if (dec.cmd == CMD_SRE && all_idle) next_dev = DV_SELF_REFRESH_STATE;
                else if (cke_fall) next_dev = any_open ? DV_ACT_PD : (all_idle ? DV_IDLE_PD : DV_ILLEGAL); // RULE_10
                else if (dec.cmd == CMD_MRW && dec.mode_addr == RESET_MA && all_idle) next_dev = DV_RESETTING; // RULE_23
                else if (dec.cmd == CMD_ILL) next_dev = DV_ILLEGAL;       // RULE_25
            end
            DV_IDLE_PD, DV_ACT_PD: if (cke_rise && cs_n_hold) next_dev = DV_NORMAL; // RULE_11
            DV_RST_PD: if (cke_rise && cs_n_hold) next_dev = init_done ? DV_NORMAL : DV_RESETTING; // RULE_14
            DV_SELF_REFRESH_STATE: if (cke_rise) next_dev = DV_NORMAL;                  // RULE_11
            DV_ILLEGAL: next_dev = DV_ILLEGAL;
            default: next_dev = DV_ILLEGAL;
        endcase
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            DEV_STATE_O <= DV_POWER_ON;
        end else begin
            DEV_STATE_O <= next_dev;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            init_cnt <= 16'hFFFF;
            rmrr_cnt <= ZERO_CNT;
        end else begin
            if (next_dev == DV_RESETTING && DEV_STATE_O == DV_POWER_ON) init_cnt <= 16'(INIT5_CYCLES);
            else if (DEV_STATE_O == DV_NORMAL && next_dev == DV_RESETTING) init_cnt <= 16'(INIT5_CYCLES);
            else if (!init_done && DEV_STATE_O != DV_POWER_ON) init_cnt <= init_cnt - 16'h0001;
            if (next_dev == DV_RST_MRR && DEV_STATE_O == DV_RESETTING) rmrr_cnt <= CYC_MRR;
            else rmrr_cnt <= dec_cnt(rmrr_cnt);
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            DQ_HIZ_O  <= 1'b1;
            DQ_TERM_O <= 1'b0;
        end else begin
            // Floating versus terminated outputs in idle low-power states
            if (next_dev inside {DV_IDLE_PD, DV_SELF_REFRESH_STATE}) begin              // RULE_15
                DQ_HIZ_O  <= !odt_s2;
                DQ_TERM_O <= odt_s2;
            end else begin
                DQ_HIZ_O  <= 1'b1;
                DQ_TERM_O <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            BANK_OPEN_O <= 8'h00;
            BANK_BUSY_O <= 8'h00;
            ILLEGAL_O   <= 1'b0;
            MODE_ADDR_O <= 8'h00;
            MODE_OP_O   <= 8'h00;
            MODE_WR_O   <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_BANKS; i++) begin
                BANK_OPEN_O[i] <= bank_st[i] inside {BK_ACTIVE, BK_READ, BK_WRITE};
                BANK_BUSY_O[i] <= !(bank_st[i] inside {BK_IDLE, BK_ACTIVE});
            end
            ILLEGAL_O <= (next_dev == DV_ILLEGAL);                        // RULE_25
            MODE_WR_O <= (dec.cmd == CMD_MRW) && (normal_go || DEV_STATE_O == DV_POWER_ON);
            if (dec.cmd == CMD_MRW) begin
                MODE_ADDR_O <= dec.mode_addr;                             // RULE_27
                MODE_OP_O   <= dec.mode_op;
            end
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    a_self_refresh_state_exit: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RULE_11
        (DEV_STATE_O == DV_SELF_REFRESH_STATE && cke_rise) |=> DEV_STATE_O == DV_NORMAL)
        else $error("self refresh exit missed");
    a_pd_entry: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RULE_10
        (DEV_STATE_O == DV_NORMAL && cke_fall && dec.cmd != CMD_SRE && all_idle) |=> DEV_STATE_O == DV_IDLE_PD)
        else $error("idle power-down entry missed");
    a_rst_mrr: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RULE_24
        (DEV_STATE_O == DV_RESETTING && !cke_fall && dec.cmd == CMD_MRR) |=> DEV_STATE_O == DV_RST_MRR)
        else $error("resetting register read missed");
    a_reset_cmd: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RULE_23
        (DEV_STATE_O == DV_POWER_ON && dec.cmd == CMD_MRW && dec.mode_addr == RESET_MA)
        |=> DEV_STATE_O == DV_RESETTING)
        else $error("reset command ignored");
    a_pre_all: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RULE_05
        (normal_go && dec.cmd == CMD_PRE && dec.all_bank_flag) |=> bank_st[7] == BK_PRECH && bank_st[0] == BK_PRECH)
        else $error("precharge all missed a bank");
    a_act_bank: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RULE_16
        (normal_go && dec.cmd == CMD_ACT && dec.bank == 3'd2 && bank_st[2] == BK_IDLE) |=> bank_st[2] == BK_ACTING)
        else $error("activate did not open bank");
    a_dq_term: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RULE_15
        (DEV_STATE_O == DV_IDLE_PD && $past(DEV_STATE_O) == DV_IDLE_PD && $stable(odt_s2)) |-> DQ_TERM_O == odt_s2)
        else $error("termination state wrong");
    a_cs_nop: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RULE_06
        cs_n_hold |-> dec.cmd == CMD_NOP)
        else $error("command decoded with select high");
    a_col_zero: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RULE_04
        dec.col[0] == 1'b0)
        else $error("lowest column bit set");

endmodule : lcd_state_tracker
`default_nettype wire

// >>> testbench/lcd_ctl_model.sv
// Controller model: drives chip select, clock enable and the command bus
`timescale 1ns/1ps
`default_nettype none
module lcd_ctl_model (
    input  wire logic       clk_i,
    output logic            cs_n_o,
    output logic            cke_o,
    output logic [9:0]      ca_o
);
    // ==========================================
    // Bus driving, all changes on falling edge
    initial begin
        cs_n_o = 1'h1;
        cke_o  = 1'h1;
        ca_o   = 10'h000;
    end
    // Deselected bus is floating: never hold the last word
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge clk_i);
            cs_n_o = 1'h1;
            ca_o   = ~ca_o;
        end
    endtask : idle
    task automatic cmd(input logic [9:0] r, input logic [9:0] f, input logic cke);
        @(negedge clk_i);
        cs_n_o = 1'h0;
        cke_o  = cke;
        ca_o   = r;
        @(negedge clk_i);
        cs_n_o = 1'h1;
        ca_o   = f;
    endtask : cmd
    task automatic set_cke(input logic v);
        @(negedge clk_i);
        cs_n_o = 1'h1;
        cke_o  = v;
        ca_o   = ~ca_o;
    endtask : set_cke
endmodule : lcd_ctl_model
`default_nettype wire

// >>> testbench/tb_lcd_state_tracker.sv
// Testbench: command sequences against a bank state model
`timescale 1ns/1ps
`default_nettype none
module tb_lcd_state_tracker;
    import lcd_pkg::*;
    logic clk, rst, cs_n, cke, odt, hiz, term, ill, mwr, k;
    logic [9:0] ca;
    logic [7:0] b_open, b_busy, m_addr, m_op, e_open, ma, op;
    lcd_dev_t dev, e_dev;
    int failures, n_checks, seed, b, n_mwr;
    // ==========================================
    // Clock, partner, design
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    lcd_ctl_model ctl (.clk_i(clk), .cs_n_o(cs_n), .cke_o(cke), .ca_o(ca));
    lcd_state_tracker #(.INIT5_CYCLES(8)) dut (.REF_CLK_I(clk), .RESET_I(rst), .CS_N_I(cs_n), .CKE_I(cke),
        .CA_I(ca), .ODT_EN_I(odt), .BANK_OPEN_O(b_open), .BANK_BUSY_O(b_busy), .DEV_STATE_O(dev),
        .DQ_HIZ_O(hiz), .DQ_TERM_O(term), .ILLEGAL_O(ill), .MODE_ADDR_O(m_addr), .MODE_OP_O(m_op),
        .MODE_WR_O(mwr));
    // Mode write strobe must be one cycle per accepted write
    always @(negedge clk) begin
        if (mwr === 1'h1) n_mwr++;
    end
    // ==========================================
    // Compare and closing tasks
    task automatic bad(input string s);
        failures++;
        $display("wrong value at %0t: %s", $time, s);
    endtask : bad
    task automatic chk_state();
        n_checks++;
        if ({b_open, b_busy, dev} !== {e_open, 8'h00, e_dev}) bad("bank or device state");
    endtask : chk_state
    task automatic chk_out(input logic [17:0] got, input logic [17:0] exp);
        n_checks++;
        if (got !== exp) bad("mode or data pins");
    endtask : chk_out
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    // Send, let every burst and timed state run out before the next command, compare
    task automatic go(input logic [9:0] r, input logic [9:0] f);
        ctl.cmd(r, f, k);
        ctl.idle(40);
        chk_state();
    endtask : go
    initial begin
        #(50 * 5000);
        failures++;
        stop_test();
    end
    // ==========================================
    // Main sequence
    initial begin
        seed = 82;
        rst = 1'h1;
        odt = 1'h0;
        k = 1'h1;
        failures = 0;
        n_checks = 0;
        n_mwr = 0;
        e_open = 8'h00;
        e_dev = DV_POWER_ON;
        repeat (12) @(negedge clk);
        rst = 1'h0;
        chk_state();
        chk_out({16'h0000, hiz, term}, 18'h00002);
        op = 8'($random(seed));
        e_dev = DV_NORMAL;
        go({6'h3F, 4'h0}, {op, 2'h0});
        ma = 8'($random(seed)) & 8'h3E;
        op = 8'($random(seed));
        go({ma[5:0], 4'h0}, {op, ma[7:6]});
        chk_out({m_addr, m_op, 2'h0}, {ma, op, 2'h0});
        chk_out({10'h000, n_mwr[7:0]}, 18'h00002);
        go({6'($random(seed)), 4'h8}, 10'($random(seed)));
        go({6'($random(seed)), 4'h4}, 10'($random(seed)));
        go({6'($random(seed)), 4'hC}, 10'($random(seed)));
        $display("test reset, mode access and refresh done");
        repeat (4) begin
            // Distinct banks, so some stay open for active power-down
            b = (b + 1 + ($random(seed) & 1)) & 7;
            e_open[b] = 1'h1;
            go({b[2:0], 5'($random(seed)), 2'h2}, 10'($random(seed)));
        end
        // Write keeps row open, read with auto-precharge closes it; C0 never sent
        go({b[2:0], 2'($random(seed)), 2'h0, 3'h1}, {9'($random(seed)), 1'h0});
        e_open[b] = 1'h0;
        go({b[2:0], 2'($random(seed)), 2'h0, 3'h5}, {9'($random(seed)), 1'h1});
        e_dev = DV_ACT_PD;
        ctl.set_cke(~cke);
        ctl.idle(10);
        chk_state();
        e_dev = DV_NORMAL;
        ctl.set_cke(~cke);
        ctl.idle(10);
        chk_state();
        $display("test activate, access, active power-down done");
        b = 0;
        while (!e_open[b]) b++;
        e_open[b] = 1'h0;
        go({b[2:0], 2'h0, 1'h0, 4'hB}, 10'($random(seed)));
        e_open = 8'h00;
        go({3'($random(seed)), 2'h0, 1'h1, 4'hB}, 10'($random(seed)));
        odt = 1'($random(seed));
        e_dev = DV_IDLE_PD;
        ctl.set_cke(~cke);
        ctl.idle(10);
        chk_state();
        chk_out({16'h0000, hiz, term}, {16'h0000, ~odt, odt});
        e_dev = DV_NORMAL;
        ctl.set_cke(~cke);
        ctl.idle(10);
        chk_state();
        odt = ~odt;
        e_dev = DV_SELF_REFRESH_STATE;
        k = 1'h0;
        ctl.cmd({6'($random(seed)), 4'h4}, 10'($random(seed)), k);
        k = 1'h1;
        ctl.idle(10);
        chk_state();
        chk_out({16'h0000, hiz, term}, {16'h0000, ~odt, odt});
        e_dev = DV_NORMAL;
        ctl.set_cke(~cke);
        ctl.idle(10);
        chk_state();
        $display("test precharge and low power done");
        e_dev = DV_ILLEGAL;
        go({6'($random(seed)), 4'h3}, 10'($random(seed)));
        chk_out({17'h00000, ill}, 18'h00001);
        $display("test undefined opcode done");
        stop_test();
    end
endmodule : tb_lcd_state_tracker
`default_nettype wire
